/* File: hdl/hrpc_defs.svh */
`ifndef HRPC_DEFS_SVH
`define HRPC_DEFS_SVH
// register byte offsets
`define HRPC_A_ROLE 8'h00
`define HRPC_A_HOP 8'h04
`define HRPC_A_POWER 8'h08
`define HRPC_A_RXTO 8'h0c
`define HRPC_A_SBASE 8'h10
`define HRPC_A_SDELTA 8'h14
`define HRPC_A_SEFF 8'h18
`define HRPC_A_RXF 8'h1c
`define HRPC_A_TXF 8'h20
`define HRPC_A_SETUP 8'h24
`define HRPC_A_STAT 8'h28
`define HRPC_A_RSSI 8'h2c
`define HRPC_A_SYSL 3'h2
`define HRPC_A_SITEL 3'h3
// field positions
`define HRPC_NA_BIT 31
`define HRPC_RXTO_EN_BIT 16
`define HRPC_CMD_ENTER 0
`define HRPC_CMD_QUIT 1
`define HRPC_CMD_KEY 2
`define HRPC_CMD_REL 3
`define HRPC_ST_REJECT 0
// ranges and reset values
`define HRPC_PWR_MIN 5'h14
`define HRPC_PWR_MAX 5'h1e
`define HRPC_RXTO_MAX 11'h5a0
`define HRPC_SEND_MIN 4'h1
`define HRPC_SEND_MAX 4'ha
`define HRPC_DELTA_MIN 5'sh16
`define HRPC_DELTA_MAX 5'sh0a
`define HRPC_FREQ_LO 20'hdc389
`define HRPC_FREQ_HI 20'he28e7
`define HRPC_HOP_DEF 3'h6
`define HRPC_LBL_LEN 30
// hop period (ms) and payload (bytes), entry 0 in the low bits
`define HRPC_HOP_MS {8'ha0, 8'h50, 8'h28, 8'h20, 8'h19, 8'h14, 8'h10, 8'h0a}
`define HRPC_HOP_BYTES {9'h150, 9'ha2, 9'h48, 9'h39, 9'h27, 9'h1e, 9'h15, 9'h09}
// timing
`define HRPC_CLK_NS 8
`define HRPC_MS_NS 1000000
`define HRPC_MIN_MS 60000
`define HRPC_SETUP_MIN 10
`define HRPC_KEY_MIN 5
`define HRPC_OKAY 2'h0
`define HRPC_SLVERR 2'h2
`endif

/* File: hdl/hrpc_pkg.sv */
package hrpc_pkg;
  typedef enum logic [1:0] {
    HRPC_MASTER = 2'b00,
    HRPC_REMOTE = 2'b01,
    HRPC_REMOTE_MF = 2'b10
  } hrpc_role_type;

  typedef enum logic [0:0] {
    HRPC_NORMAL = 1'b0,
    HRPC_SETUP = 1'b1
  } hrpc_mode_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    hrpc_role_type role;
    logic mfreq;
    logic [2:0] hop;
    logic [7:0] hop_ms;
    logic [8:0] hop_bytes;
    logic [4:0] power;
    logic rxto_en;
    logic [10:0] rxto_min;
    logic [3:0] send_base;
    logic signed [4:0] send_delta;
    logic [3:0] retx;
    logic [19:0] rxf;
    logic [19:0] txf;
    logic rxf_set;
    logic txf_set;
    hrpc_mode_type mode;
    logic keyed;
    logic hopping;
    logic [19:0] synth_tx;
    logic [19:0] synth_rx;
    logic [7:0] rssi;
    logic alarm;
    logic reject;
    logic [31:0] ms_cnt;
    logic [31:0] setup_ms;
    logic [31:0] key_ms;
    logic [31:0] rx_ms;
    logic [10:0] rx_min;
    logic [29:0][7:0] sys_lbl;
    logic [29:0][7:0] site_lbl;
  } hrpc_state_type;
endpackage

/* File: hdl/hrpc_top.sv */
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hrpc_defs.svh"

module hrpc_top import hrpc_pkg::*; #(
  parameter int MS_CYC = `HRPC_MS_NS / `HRPC_CLK_NS,
  parameter int MIN_MS = `HRPC_MIN_MS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sync_locked,
  input wire logic sync_msg,
  input wire logic rx_packet,
  input wire logic [7:0] rssi_avg_in,
  input wire logic [7:0] rssi_raw_in,
  output logic [1:0] role,
  output logic master_freq_set,
  output logic [2:0] hop_setting,
  output logic [7:0] hop_period_ms,
  output logic [8:0] hop_max_bytes,
  output logic [4:0] rf_power_level,
  output logic [3:0] retx_count,
  output logic hopping_en,
  output logic tx_key,
  output logic [19:0] synth_tx_khz,
  output logic [19:0] synth_rx_khz,
  output logic receive_timeout_alarm
);

  localparam logic [31:0] MS_LAST = 32'(MS_CYC - 1);
  localparam logic [31:0] MIN_LAST = 32'(MIN_MS - 1);
  localparam logic [31:0] SETUP_LAST = 32'(`HRPC_SETUP_MIN * MIN_MS - 1);
  localparam logic [31:0] KEY_LAST = 32'(`HRPC_KEY_MIN * MIN_MS - 1);

  // counters are 32 bits wide; longer minutes would wrap silently
  if (MS_CYC < 1 || MIN_MS < 1 || MIN_MS > 200000000) begin : g_bad_param
    $error("hrpc_top: MS_CYC and MIN_MS out of range");
  end

  hrpc_state_type q;
  hrpc_state_type d;

  // scratch for the register decode, the timers and the send count
  logic ok;
  logic [7:0] wa;
  logic [4:0] idx;
  logic signed [5:0] sum;
  logic [19:0] rxf_eff;
  logic [19:0] txf_eff;
  logic quit;
  logic ms_tick;

  always_comb begin
    d = q;
    ok = 1'b1;
    wa = q.awaddr;
    idx = 5'h0;
    quit = 1'b0;
    ms_tick = (q.ms_cnt == MS_LAST);
    // free-running millisecond prescaler shared by all timers
    d.ms_cnt = ms_tick ? 32'h0 : q.ms_cnt + 32'h1;

    // address and data channels latch independently, in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_full = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_full = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // write executes once both halves are held and the response slot is free
    if (q.aw_full && q.w_full && !q.bvalid) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      case (wa)
        `HRPC_A_ROLE: begin
          if (q.wdata[1:0] == HRPC_MASTER || q.wdata[1:0] == HRPC_REMOTE ||
              q.wdata[1:0] == HRPC_REMOTE_MF) begin
            d.role = hrpc_role_type'(q.wdata[1:0]);
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_HOP: begin
          if (q.role == HRPC_MASTER) begin
            d.hop = q.wdata[2:0];
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_POWER: begin
          if (q.wdata[31:5] == 27'h0 && q.wdata[4:0] >= `HRPC_PWR_MIN &&
              q.wdata[4:0] <= `HRPC_PWR_MAX) begin
            d.power = q.wdata[4:0];
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_RXTO: begin
          if (q.wdata[15:11] == 5'h0 && q.wdata[10:0] <= `HRPC_RXTO_MAX) begin
            d.rxto_en = q.wdata[`HRPC_RXTO_EN_BIT];
            d.rxto_min = q.wdata[10:0];
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_SBASE: begin
          if (q.role == HRPC_MASTER && q.wdata[3:0] >= `HRPC_SEND_MIN &&
              q.wdata[3:0] <= `HRPC_SEND_MAX && q.wdata[31:4] == 28'h0) begin
            d.send_base = q.wdata[3:0];
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_SDELTA: begin
          if ($signed(q.wdata[4:0]) >= `HRPC_DELTA_MIN &&
              $signed(q.wdata[4:0]) <= `HRPC_DELTA_MAX) begin
            d.send_delta = $signed(q.wdata[4:0]);
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_RXF, `HRPC_A_TXF: begin
          if (q.wdata[19:0] >= `HRPC_FREQ_LO && q.wdata[19:0] <= `HRPC_FREQ_HI) begin
            if (wa == `HRPC_A_RXF) begin
              d.rxf = q.wdata[19:0];
              d.rxf_set = 1'b1;
            end else begin
              d.txf = q.wdata[19:0];
              d.txf_set = 1'b1;
            end
          end else begin
            ok = 1'b0;
          end
        end
        `HRPC_A_SETUP: begin
          if (q.wdata[`HRPC_CMD_ENTER] && q.mode == HRPC_NORMAL) begin
            d.mode = HRPC_SETUP;
            d.setup_ms = 32'h0;
          end
          // key and release only mean something inside setup
          if (q.mode == HRPC_SETUP && q.wdata[`HRPC_CMD_KEY]) begin
            d.keyed = 1'b1;
            d.key_ms = 32'h0;
          end
          if (q.wdata[`HRPC_CMD_REL]) begin
            d.keyed = 1'b0;
          end
          if (q.wdata[`HRPC_CMD_QUIT]) begin
            quit = 1'b1;
          end
        end
        `HRPC_A_STAT: begin
          if (q.wdata[`HRPC_ST_REJECT]) begin
            d.reject = 1'b0;
          end
        end
        default: begin
          if (wa[7:5] == `HRPC_A_SYSL || wa[7:5] == `HRPC_A_SITEL) begin
            // byte lanes map to characters; bytes past the last are dropped
            for (int i = 0; i < 4; i++) begin
              idx = 5'({wa[4:2], 2'(i)});
              if (q.wstrb[i] && idx < 5'(`HRPC_LBL_LEN)) begin
                if (wa[7:5] == `HRPC_A_SYSL) begin
                  d.sys_lbl[idx] = q.wdata[8*i +: 8];
                end else begin
                  d.site_lbl[idx] = q.wdata[8*i +: 8];
                end
              end
            end
          end else begin
            ok = 1'b0;
          end
        end
      endcase
      d.bresp = ok ? `HRPC_OKAY : `HRPC_SLVERR;
      if (!ok) begin
        d.reject = 1'b1; // sticky, set beats the clear
      end
    end

    // setup exit timer and keying watchdog
    if (q.mode == HRPC_SETUP && ms_tick) begin
      d.setup_ms = q.setup_ms + 32'h1;
      if (q.setup_ms == SETUP_LAST) begin
        quit = 1'b1;
      end
    end
    if (q.keyed && ms_tick) begin
      d.key_ms = q.key_ms + 32'h1;
      if (q.key_ms == KEY_LAST) begin
        d.keyed = 1'b0;
      end
    end
    if (quit) begin
      d.mode = HRPC_NORMAL;
      d.keyed = 1'b0;
    end

    // receive timeout: minutes since last data packet
    if (rx_packet) begin
      d.rx_ms = 32'h0;
      d.rx_min = 11'h0;
    end else if (ms_tick) begin
      d.rx_ms = (q.rx_ms == MIN_LAST) ? 32'h0 : q.rx_ms + 32'h1;
      if (q.rx_ms == MIN_LAST && q.rx_min != 11'h7ff) begin
        d.rx_min = q.rx_min + 11'h1;
      end
    end
    d.alarm = d.rxto_en && !rx_packet && (d.rx_min >= d.rxto_min);

    // signal strength sampling
    if (q.mode == HRPC_SETUP) begin
      d.rssi = rssi_raw_in;
    end else if (q.role != HRPC_MASTER && sync_msg) begin
      d.rssi = rssi_avg_in;
    end

    // net retransmission count, saturated whatever the delta
    sum = $signed({2'b00, q.send_base}) + 6'(q.send_delta);
    if (sum < $signed({2'b00, `HRPC_SEND_MIN})) begin
      d.retx = `HRPC_SEND_MIN;
    end else if (sum > $signed({2'b00, `HRPC_SEND_MAX})) begin
      d.retx = `HRPC_SEND_MAX;
    end else begin
      d.retx = sum[3:0];
    end

    // unprogrammed test frequencies follow the role's default
    rxf_eff = q.rxf_set ? q.rxf : (q.role == HRPC_MASTER ? `HRPC_FREQ_HI : `HRPC_FREQ_LO);
    txf_eff = q.txf_set ? q.txf : (q.role == HRPC_MASTER ? `HRPC_FREQ_HI : `HRPC_FREQ_LO);
    d.hopping = (d.mode == HRPC_NORMAL);
    d.synth_rx = (d.mode == HRPC_SETUP) ? rxf_eff : 20'h0;
    d.synth_tx = (d.mode == HRPC_SETUP) ? txf_eff : 20'h0;
    d.mfreq = (q.role != HRPC_REMOTE);
    d.hop_ms = 8'(`HRPC_HOP_MS >> (8 * q.hop));
    d.hop_bytes = 9'(`HRPC_HOP_BYTES >> (9 * q.hop));

    // read channel: one beat, answered the cycle after the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0;
      case (s_axi_araddr)
        `HRPC_A_ROLE: d.rdata[1:0] = q.role;
        `HRPC_A_HOP: begin
          d.rdata[2:0] = q.hop;
          d.rdata[`HRPC_NA_BIT] = (q.role != HRPC_MASTER) && !sync_locked;
        end
        `HRPC_A_POWER: d.rdata[4:0] = q.power;
        `HRPC_A_RXTO: d.rdata = {15'h0, q.rxto_en, 5'h0, q.rxto_min};
        `HRPC_A_SBASE: d.rdata[3:0] = q.send_base;
        `HRPC_A_SDELTA: d.rdata = 32'(q.send_delta);
        `HRPC_A_SEFF: begin
          d.rdata[3:0] = q.retx;
          d.rdata[`HRPC_NA_BIT] = (q.role != HRPC_MASTER) && !sync_locked;
        end
        `HRPC_A_RXF: d.rdata[19:0] = rxf_eff;
        `HRPC_A_TXF: d.rdata[19:0] = txf_eff;
        `HRPC_A_STAT: d.rdata[5:0] = {q.mode, q.keyed, q.hopping, sync_locked, q.alarm, q.reject};
        `HRPC_A_RSSI: begin
          d.rdata[7:0] = q.rssi;
          d.rdata[`HRPC_NA_BIT] = (q.role == HRPC_MASTER) && (q.mode == HRPC_NORMAL);
        end
        default: begin
          if (s_axi_araddr[7:5] == `HRPC_A_SYSL || s_axi_araddr[7:5] == `HRPC_A_SITEL) begin
            for (int i = 0; i < 4; i++) begin
              idx = 5'({s_axi_araddr[4:2], 2'(i)});
              if (idx < 5'(`HRPC_LBL_LEN)) begin
                d.rdata[8*i +: 8] = (s_axi_araddr[7:5] == `HRPC_A_SYSL) ?
                  q.sys_lbl[idx] : q.site_lbl[idx];
              end
            end
          end
        end
      endcase
    end
    // readies come from flops; at most one write and one read in flight
    d.awready = !d.aw_full && !d.bvalid;
    d.wready = !d.w_full && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.role <= HRPC_REMOTE;
      q.mfreq <= 1'b0;
      q.hop <= `HRPC_HOP_DEF;
      q.power <= `HRPC_PWR_MAX;
      q.send_base <= `HRPC_SEND_MIN;
      q.retx <= `HRPC_SEND_MIN;
      q.mode <= HRPC_NORMAL;
      q.hopping <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.bresp & 2'h0;
  assign role = q.role;
  assign master_freq_set = q.mfreq;
  assign hop_setting = q.hop;
  assign hop_period_ms = q.hop_ms;
  assign hop_max_bytes = q.hop_bytes;
  assign rf_power_level = q.power;
  assign retx_count = q.retx;
  assign hopping_en = q.hopping;
  assign tx_key = q.keyed;
  assign synth_tx_khz = q.synth_tx;
  assign synth_rx_khz = q.synth_rx;
  assign receive_timeout_alarm = q.alarm;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  wire wr_fire = q.aw_full && q.w_full && !q.bvalid;

  hop_master_only_a: assert property (
    wr_fire && q.awaddr == `HRPC_A_HOP && q.role != HRPC_MASTER |=> $stable(q.hop))
    else $error("hop setting changed at a remote");
  reject_resp_a: assert property (
    wr_fire && q.awaddr == `HRPC_A_SBASE && q.role != HRPC_MASTER
    |=> s_axi_bvalid && s_axi_bresp == `HRPC_SLVERR && q.reject && $stable(q.send_base))
    else $error("master-only write at remote not refused");
  power_range_a: assert property (
    rf_power_level >= `HRPC_PWR_MIN && rf_power_level <= `HRPC_PWR_MAX)
    else $error("rf power out of range");
  retx_clamp_a: assert property (
    ##1 retx_count == ($past(sum) < 6'sd1 ? 4'h1 : $past(sum) > 6'sd10 ? 4'ha : $past(sum[3:0])))
    else $error("retransmission count not base plus delta clamped");
  setup_stops_hop_a: assert property (
    q.mode == HRPC_SETUP |-> !hopping_en && synth_rx_khz >= `HRPC_FREQ_LO)
    else $error("hopping during setup");
  key_only_setup_a: assert property (
    tx_key |-> q.mode == HRPC_SETUP && !hopping_en)
    else $error("transmitter keyed outside setup");
  quit_exit_a: assert property (
    wr_fire && q.awaddr == `HRPC_A_SETUP && q.wdata[`HRPC_CMD_QUIT] |=> q.mode == HRPC_NORMAL ##1 hopping_en)
    else $error("quit did not restore hopping");
  setup_timer_a: assert property (
    q.mode == HRPC_SETUP |-> q.setup_ms <= SETUP_LAST)
    else $error("setup outlived its timer");
  rssi_master_na_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `HRPC_A_RSSI && q.role == HRPC_MASTER &&
    q.mode == HRPC_NORMAL |=> s_axi_rvalid && s_axi_rdata[`HRPC_NA_BIT])
    else $error("master gave signal strength outside setup");
  rssi_sync_a: assert property (
    q.mode == HRPC_NORMAL && q.role != HRPC_MASTER && sync_msg |=> q.rssi == $past(rssi_avg_in))
    else $error("signal strength not latched on sync");
  rxto_alarm_a: assert property (
    receive_timeout_alarm |-> q.rxto_en && q.rx_min >= q.rxto_min)
    else $error("receive timeout alarm without cause");

endmodule
`default_nettype wire

/* File: sim/hrpc_term.sv */
`timescale 1ns/1ps
`default_nettype none
// operator terminal: axi4-lite master that issues set and display accesses
module hrpc_term (
  input wire logic clk,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0;
  end

  // one write; a released payload is inverted so a late sample sees junk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // one read; waits for the answer without assuming a latency
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hrpc_defs.svh"
module tb import hrpc_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rssi_avg_in, rssi_raw_in, hop_period_ms;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, retx_count;
  logic [1:0] s_axi_bresp, s_axi_rresp, role, br;
  logic sync_locked, sync_msg, rx_packet, master_freq_set, hopping_en, tx_key;
  logic receive_timeout_alarm;
  logic [2:0] hop_setting;
  logic [8:0] hop_max_bytes;
  logic [4:0] rf_power_level;
  logic [19:0] synth_tx_khz, synth_rx_khz;
  int fail_count = 0;
  int checked = 0;
  // hop period and payload per setting, base/delta/effective send counts
  int hop_ms_t[8] = '{10, 16, 20, 25, 32, 40, 80, 160};
  int hop_by_t[8] = '{9, 21, 30, 39, 57, 72, 162, 336};
  int sb_t[4] = '{10, 1, 5, 10};
  int sd_t[4] = '{5, 22, 30, 0};
  int se_t[4] = '{10, 1, 3, 10};

  // 125 mhz clock
  always #(`HRPC_CLK_NS / 2) clk = ~clk;

  // short prescalers: one minute is 12 cycles
  hrpc_top #(.MS_CYC(4), .MIN_MS(3)) hrpc_top_i (
    .clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sync_locked, .sync_msg, .rx_packet,
    .rssi_avg_in, .rssi_raw_in, .role, .master_freq_set, .hop_setting, .hop_period_ms,
    .hop_max_bytes, .rf_power_level, .retx_count, .hopping_en, .tx_key,
    .synth_tx_khz, .synth_rx_khz, .receive_timeout_alarm
  );

  hrpc_term hrpc_term_i (
    .clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    hrpc_term_i.wr(a, d, 4'hf, br);
    check(32'(br), 32'(e));
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] e);
    hrpc_term_i.rd(a, rv);
    check(rv, e);
  endtask

  // settle past the edge before looking at outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results;
    $display("counts: %0d checked, %0d failed", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {sync_locked, sync_msg, rx_packet} = 3'h0;
    {rssi_avg_in, rssi_raw_in} = 16'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    check(32'(role), 32'(HRPC_REMOTE));
    check(32'(master_freq_set), 32'h0);
    check(32'(hop_period_ms), 32'h50);
    check(32'(hop_max_bytes), 32'ha2);
    check(32'(rf_power_level), 32'h1e);
    check(32'(retx_count), 32'h1);
    check(32'(receive_timeout_alarm), 32'h0);
    r(`HRPC_A_RXTO, 32'h0);
    r(`HRPC_A_RXF, 32'hdc389);
    hrpc_term_i.rd(`HRPC_A_HOP, rv);
    check(32'(rv[31]), 32'h1);
    hrpc_term_i.rd(`HRPC_A_SEFF, rv);
    check(32'(rv[31]), 32'h1);
    $display("test defaults done");
    // remote synced: reads allowed, master-only writes refused
    @(posedge clk);
    sync_locked <= 1'b1;
    r(`HRPC_A_HOP, 32'h6);
    r(`HRPC_A_SEFF, 32'h1);
    w(`HRPC_A_HOP, 32'h2, `HRPC_SLVERR);
    check(32'(hop_setting), 32'h6);
    r(`HRPC_A_STAT, 32'h0d);
    w(`HRPC_A_STAT, 32'h1, `HRPC_OKAY);
    r(`HRPC_A_STAT, 32'h0c);
    w(`HRPC_A_SBASE, 32'h5, `HRPC_SLVERR);
    w(`HRPC_A_SDELTA, 32'h3, `HRPC_OKAY);
    cyc(2);
    check(32'(retx_count), 32'h4);
    $display("test remote refusals done");
    // role codes; remote on master frequencies stays a remote
    w(`HRPC_A_ROLE, 32'h2, `HRPC_OKAY);
    cyc(2);
    check(32'(role), 32'(HRPC_REMOTE_MF));
    check(32'(master_freq_set), 32'h1);
    w(`HRPC_A_HOP, 32'h1, `HRPC_SLVERR);
    w(`HRPC_A_ROLE, 32'h3, `HRPC_SLVERR);
    w(`HRPC_A_ROLE, 32'h0, `HRPC_OKAY);
    cyc(2);
    check(32'(role), 32'(HRPC_MASTER));
    r(`HRPC_A_RXF, 32'he28e7);
    for (int i = 0; i < 8; i++) begin
      w(`HRPC_A_HOP, 32'(i), `HRPC_OKAY);
      cyc(2);
      check(32'(hop_period_ms), 32'(hop_ms_t[i]));
      check(32'(hop_max_bytes), 32'(hop_by_t[i]));
    end
    $display("test role and hop done");
    // power range edges
    w(`HRPC_A_POWER, 32'h14, `HRPC_OKAY);
    w(`HRPC_A_POWER, 32'h13, `HRPC_SLVERR);
    w(`HRPC_A_POWER, 32'h1f, `HRPC_SLVERR);
    cyc(1);
    check(32'(rf_power_level), 32'h14);
    // send count clamping, including both saturation ends
    for (int i = 0; i < 4; i++) begin
      w(`HRPC_A_SBASE, 32'(sb_t[i]), `HRPC_OKAY);
      w(`HRPC_A_SDELTA, 32'(sd_t[i]), `HRPC_OKAY);
      cyc(2);
      check(32'(retx_count), 32'(se_t[i]));
      r(`HRPC_A_SEFF, 32'(se_t[i]));
    end
    w(`HRPC_A_SBASE, 32'h0, `HRPC_SLVERR);
    w(`HRPC_A_SBASE, 32'hb, `HRPC_SLVERR);
    w(`HRPC_A_SDELTA, 32'hb, `HRPC_SLVERR);
    w(`HRPC_A_SDELTA, 32'h16, `HRPC_OKAY);
    r(`HRPC_A_SDELTA, 32'hfffffff6);
    hrpc_term_i.rd(`HRPC_A_RSSI, rv);
    check(32'(rv[31]), 32'h1);
    $display("test power and send done");
    // labels: byte strobes and the 30-character limit
    w(8'h40, 32'h44434241, `HRPC_OKAY);
    hrpc_term_i.wr(8'h40, 32'h00005a00, 4'h2, br);
    check(32'(br), 32'(`HRPC_OKAY));
    r(8'h40, 32'h44435a41);
    w(8'h7c, 32'h64636261, `HRPC_OKAY);
    r(8'h7c, 32'h00006261);
    $display("test labels done");
    // transmit test frequency, receive test frequency at both range limits, then setup mode
    w(`HRPC_A_TXF, 32'hdc500, `HRPC_OKAY);
    w(`HRPC_A_RXF, 32'hdc388, `HRPC_SLVERR);
    w(`HRPC_A_RXF, 32'he28e8, `HRPC_SLVERR);
    w(`HRPC_A_RXF, 32'hdc389, `HRPC_OKAY);
    w(`HRPC_A_RXF, 32'he28e7, `HRPC_OKAY);
    w(`HRPC_A_SETUP, 32'h1, `HRPC_OKAY);
    cyc(2);
    check(32'(hopping_en), 32'h0);
    check(32'(synth_tx_khz), 32'hdc500);
    check(32'(synth_rx_khz), 32'he28e7);
    @(posedge clk);
    rssi_raw_in <= 8'h33;
    r(`HRPC_A_RSSI, 32'h33);
    w(`HRPC_A_SETUP, 32'h4, `HRPC_OKAY);
    cyc(1);
    check(32'(tx_key), 32'h1);
    w(`HRPC_A_SETUP, 32'h8, `HRPC_OKAY);
    cyc(1);
    check(32'(tx_key), 32'h0);
    w(`HRPC_A_SETUP, 32'h4, `HRPC_OKAY);
    cyc(20);
    check(32'(tx_key), 32'h1);
    cyc(50);
    check(32'(tx_key), 32'h0);
    w(`HRPC_A_SETUP, 32'h2, `HRPC_OKAY);
    cyc(2);
    check(32'(hopping_en), 32'h1);
    check(32'(synth_tx_khz), 32'h0);
    // auto exit ten minutes after entry
    w(`HRPC_A_SETUP, 32'h1, `HRPC_OKAY);
    cyc(110);
    check(32'(hopping_en), 32'h0);
    cyc(20);
    check(32'(hopping_en), 32'h1);
    $display("test setup done");
    // remote latches averaged strength only on a sync message
    w(`HRPC_A_ROLE, 32'h1, `HRPC_OKAY);
    @(posedge clk);
    rssi_avg_in <= 8'h40;
    sync_msg <= 1'b1;
    @(posedge clk);
    sync_msg <= 1'b0;
    rssi_avg_in <= 8'h55;
    r(`HRPC_A_RSSI, 32'h40);
    // receive timeout of two minutes, cleared by a packet
    w(`HRPC_A_RXTO, 32'h10002, `HRPC_OKAY);
    w(`HRPC_A_RXTO, 32'h105a1, `HRPC_SLVERR);
    @(posedge clk);
    rx_packet <= 1'b1;
    @(posedge clk);
    rx_packet <= 1'b0;
    cyc(10);
    check(32'(receive_timeout_alarm), 32'h0);
    cyc(30);
    check(32'(receive_timeout_alarm), 32'h1);
    @(posedge clk);
    rx_packet <= 1'b1;
    @(posedge clk);
    rx_packet <= 1'b0;
    cyc(2);
    check(32'(receive_timeout_alarm), 32'h0);
    w(`HRPC_A_RXTO, 32'h105a0, `HRPC_OKAY);
    // zero minutes alarms at once, disabling drops it
    w(`HRPC_A_RXTO, 32'h10000, `HRPC_OKAY);
    cyc(1);
    check(32'(receive_timeout_alarm), 32'h1);
    w(`HRPC_A_RXTO, 32'h0, `HRPC_OKAY);
    cyc(1);
    check(32'(receive_timeout_alarm), 32'h0);
    $display("test rssi and timeout done");
    results();
  end

  // watchdog well beyond the several hundred cycles the tests take
  initial begin
    #100000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
